// ==== rtl/adm_cic.v ====
// Cascaded integrator-comb decimator with a short FIR smoother
`timescale 1ns/1ps
module adm_cic #(
  parameter WIDTH = 32
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             mod_tick,
  input  wire             bit_in,
  input  wire [7:0]       osr,
  output reg  [WIDTH-1:0] sample,
  output reg              sample_valid
);
  // ----------------------------------------
  // Integrators, combs and decimation count
  // ----------------------------------------
  reg signed [WIDTH-1:0] int1;
  reg signed [WIDTH-1:0] int2;
  reg signed [WIDTH-1:0] int3;
  reg signed [WIDTH-1:0] d1;
  reg signed [WIDTH-1:0] d2;
  reg signed [WIDTH-1:0] d3;
  reg signed [WIDTH-1:0] fir_prev;
  reg [7:0]              count;
  wire signed [WIDTH-1:0] in_val = bit_in ? {{(WIDTH-1){1'b0}}, 1'b1}
                                          : {WIDTH{1'b1}};
  wire signed [WIDTH-1:0] c1 = int3 - d1;
  wire signed [WIDTH-1:0] c2 = c1 - d2;
  wire signed [WIDTH-1:0] c3 = c2 - d3;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int1 <= {WIDTH{1'b0}};
      int2 <= {WIDTH{1'b0}};
      int3 <= {WIDTH{1'b0}};
      d1 <= {WIDTH{1'b0}};
      d2 <= {WIDTH{1'b0}};
      d3 <= {WIDTH{1'b0}};
      fir_prev <= {WIDTH{1'b0}};
      count <= 8'h00;
      sample <= {WIDTH{1'b0}};
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (mod_tick) begin
        int1 <= int1 + in_val;
        int2 <= int2 + int1;
        int3 <= int3 + int2;
        if (count >= osr - 8'h01) begin
          count <= 8'h00;
          d1 <= int3;
          d2 <= c1;
          d3 <= c2;
          fir_prev <= c3;
          sample <= (c3 >>> 1) + (fir_prev >>> 1);
          sample_valid <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule // adm_cic

// ==== rtl/adm_defines.vh ====
// Constants for the ADC decimation and dc-measurement block
`ifndef ADM_DEFINES_VH
`define ADM_DEFINES_VH
`define ADM_ADDR_CONFIG     8'h66
`define ADM_ADDR_CONTROL    8'h67
`define ADM_ADDR_RESULT_HI  8'h68
`define ADM_ADDR_RESULT_MID 8'h69
`define ADM_ADDR_RESULT_LO  8'h6A
`define ADM_BIT_DC_ENABLE   7
`define ADM_BIT_DC_MODE     5
`define ADM_BIT_LATCH       6
`define ADM_BIT_PER_RESET   5
`define ADM_FIELD_HI        4
`define ADM_FIELD_LO        0
`define ADM_PIN_FUNC_MODCLK 4'hA
`define ADM_FILTER_A        2'h0
`define ADM_FILTER_B        2'h1
`define ADM_FILTER_C        2'h2
`define ADM_OSR_128         8'h80
`define ADM_OSR_64          8'h40
`define ADM_OSR_32          8'h20
`define ADM_LEN_MIN         5'h01
`define ADM_LEN_MAX         5'h14
`define ADM_CIC_SHIFT_MAX   5'h15
`endif

// ==== rtl/adm_top.v ====
// ADC decimation back end with dc measurement
// Operation
// - Decimate modulator rate down to output rate; filter follows processing block.
// - Decimation is a CIC stage followed by linear-phase FIR.
// - Filter A also serves 96 kHz at oversampling 64.
// - Filter B serves up to 96 kHz at oversampling 64.
// - Filter C with oversampling 32 serves 192 ksps.
// - Each output period hand a left/right 32-bit word pair.
// - Serial interface rounds each word to configured length.
// - Same mono sample goes to left and right slots.
// - Pin function 1010 drives modulator clock on general pin one.
// - Microphone bit sampled on each modulator clock rising edge.
// - Config bit 7 enables dc measurement while not recording.
// - Result is 24-bit 2.22 value over three read-back registers.
// - Config bit 5 picks averaging (0) or IIR (1).
// - Field 4..0 sets averaging length 2^D, D from 1 to 20.
// - Same field sets IIR coefficient in IIR mode.
// - Control bit 5 resets averager every 2^R modulator clocks.
`timescale 1ns/1ps
`include "adm_defines.vh"
module adm_top #(
  parameter MOD_DIV = 8
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire [3:0]  pin_function,
  input  wire [1:0]  filter_select,
  input  wire [7:0]  adc_oversampling_ratio,
  input  wire        dig_mic_enable,
  input  wire        mod_bit,
  input  wire        serial_data_in,
  input  wire [4:0]  word_length,
  output reg         general_pin_one,
  output reg         general_pin_one_oe,
  output reg  [31:0] left_word,
  output reg  [31:0] right_word,
  output reg         word_valid
);
  // ----------------------------------------
  // Modulator clock generation
  // ----------------------------------------
  reg [7:0] div_cnt;
  reg       mod_clk;
  // One pulse per modulator period, at the internal rising edge
  wire      mod_rise = (div_cnt == MOD_DIV - 1) && !mod_clk;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 8'h00;
      mod_clk <= 1'b0;
    end else if (div_cnt == MOD_DIV - 1) begin
      div_cnt <= 8'h00;
      mod_clk <= ~mod_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  // Modulator clock driven out on the general pin
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      general_pin_one    <= 1'b0;
      general_pin_one_oe <= 1'b0;
    end else begin
      general_pin_one_oe <= (pin_function == `ADM_PIN_FUNC_MODCLK);
      general_pin_one    <= (pin_function == `ADM_PIN_FUNC_MODCLK) & mod_clk;
    end
  end

  // ----------------------------------------
  // Input selection and decimation
  // ----------------------------------------
  reg         in_bit;
  // Microphone stream replaces the internal modulator bit
  wire        eff_in = dig_mic_enable ? serial_data_in : mod_bit;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_bit <= 1'b0;
    end else if (mod_rise) begin
      in_bit <= eff_in;
    end
  end
  // Filter type only restricts the legal oversampling ratio
  function [7:0] pick_osr;
    input [1:0] sel;
    input [7:0] req;
    begin
      case (sel)
        `ADM_FILTER_A: pick_osr = (req == `ADM_OSR_64) ? `ADM_OSR_64 : `ADM_OSR_128;
        `ADM_FILTER_B: pick_osr = `ADM_OSR_64;
        `ADM_FILTER_C: pick_osr = `ADM_OSR_32;
        default:       pick_osr = req;
      endcase
    end
  endfunction
  wire [7:0]  osr = pick_osr(filter_select, adc_oversampling_ratio);
  wire [31:0] dec_sample;
  wire        dec_valid;
  adm_cic #(.WIDTH(32)) u_cic (
    .clk          (clk),
    .rst          (rst),
    .mod_tick     (mod_rise),
    .bit_in       (in_bit),
    .osr          (osr),
    .sample       (dec_sample),
    .sample_valid (dec_valid)
  );

  // ----------------------------------------
  // Serial interface hand-off
  // ----------------------------------------
  // Bits kept for a word of the given length
  function [31:0] keep_mask;
    input [4:0] len;
    begin
      if (len == 5'h00) keep_mask = 32'hFFFFFFFF;
      else keep_mask = ~(32'hFFFFFFFF >> len);
    end
  endfunction
  // Half of the lowest kept bit, added before the cut
  function [31:0] round_half;
    input [4:0] len;
    begin
      if (len == 5'h00) round_half = 32'h00000000;
      else round_half = 32'h80000000 >> len;
    end
  endfunction
  function [31:0] round_word;
    input [31:0] w;
    input [4:0]  len;
    begin
      round_word = (w + round_half(len)) & keep_mask(len);
    end
  endfunction
  // Register storage, declared ahead of its first reader
  reg [7:0] cfg;
  reg [7:0] ctl;
  // Words go out only while the channel records
  wire recording = dec_valid & ~cfg[`ADM_BIT_DC_ENABLE];
  // Same rounded sample into both slots
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      left_word  <= 32'h00000000;
      right_word <= 32'h00000000;
      word_valid <= 1'b0;
    end else begin
      word_valid <= recording;
      if (recording) begin
        left_word  <= round_word(dec_sample, word_length);
        right_word <= round_word(dec_sample, word_length);
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= 8'h00;
      ctl <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == `ADM_ADDR_CONFIG)  cfg <= reg_wdata;
      if (reg_addr == `ADM_ADDR_CONTROL) ctl <= reg_wdata;
    end
  end
  // Length settings outside 1..20 are pulled to the nearest end
  function [4:0] clamp_len;
    input [4:0] v;
    begin
      if (v < `ADM_LEN_MIN) clamp_len = `ADM_LEN_MIN;
      else if (v > `ADM_LEN_MAX) clamp_len = `ADM_LEN_MAX;
      else clamp_len = v;
    end
  endfunction
  // Settings decoded from the two registers
  wire       dc_on   = cfg[`ADM_BIT_DC_ENABLE];
  wire       iir_on  = cfg[`ADM_BIT_DC_MODE];
  wire [4:0] d_len   = cfg[`ADM_FIELD_HI:`ADM_FIELD_LO];
  wire [4:0] d_clip  = clamp_len(d_len);
  wire       per_rst = ctl[`ADM_BIT_PER_RESET];
  wire [4:0] r_exp   = ctl[`ADM_FIELD_HI:`ADM_FIELD_LO];
  wire       latch   = ctl[`ADM_BIT_LATCH];

  // ----------------------------------------
  // DC measurement filters
  // ----------------------------------------
  reg  signed [47:0] acc;
  reg         [31:0] avg_cnt;
  reg         [31:0] rst_cnt;
  reg  signed [23:0] dc_value;
  reg  signed [23:0] readback;
  wire signed [47:0] samp = {{24{dec_sample[31]}}, dec_sample[31:8]};
  wire [31:0]        avg_len = 32'h00000001 << d_clip;
  wire [31:0]        rst_per = 32'h00000001 << r_exp;
  wire               per_hit = per_rst && (rst_cnt >= rst_per - 32'h00000001);
  wire signed [47:0] avg_sum = (acc + samp) >>> d_clip;
  // Periodic reset counter, in modulator clock periods
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_cnt <= 32'h00000000;
    end else if (!dc_on) begin
      rst_cnt <= 32'h00000000;
    end else if (mod_rise) begin
      rst_cnt <= per_hit ? 32'h00000000 : rst_cnt + 32'h00000001;
    end
  end
  // Averaging and IIR filters on the decimated samples
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc      <= 48'h000000000000;
      avg_cnt  <= 32'h00000000;
      dc_value <= 24'h000000;
    end else if (!dc_on) begin
      acc     <= 48'h000000000000;
      avg_cnt <= 32'h00000000;
    end else begin
      if (!iir_on && mod_rise && per_hit) begin
        acc     <= 48'h000000000000;
        avg_cnt <= 32'h00000000;
      end else if (dec_valid) begin
        if (iir_on) begin
          acc      <= acc + ((samp - acc) >>> d_clip);
          dc_value <= acc[23:0];
        end else if (avg_cnt >= avg_len - 32'h00000001) begin
          acc      <= 48'h000000000000;
          avg_cnt  <= 32'h00000000;
          dc_value <= avg_sum[23:0];
        end else begin
          acc     <= acc + samp;
          avg_cnt <= avg_cnt + 32'h00000001;
        end
      end
    end
  end

  // ----------------------------------------
  // Read-back latch control
  // ----------------------------------------
  // Open until the latch bit rises, then held while it stays set
  localparam LT_OPEN = 2'b01;
  localparam LT_HOLD = 2'b10;
  reg [1:0] lt_state;
  reg [1:0] next_lt_state;
  reg       capture;
  always @* begin
    next_lt_state = lt_state;
    capture       = 1'b0;
    case (lt_state)
      LT_OPEN: begin
        if (latch) begin
          next_lt_state = LT_HOLD;
          capture       = 1'b1;
        end
      end
      LT_HOLD: begin
        if (!latch) begin
          next_lt_state = LT_OPEN;
        end
      end
      default: begin
        next_lt_state = LT_OPEN;
      end
    endcase
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lt_state <= LT_OPEN;
      readback <= 24'h000000;
    end else begin
      lt_state <= next_lt_state;
      if (capture) begin
        readback <= dc_value;
      end
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Registered read data, held until the next read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ADM_ADDR_CONFIG:     reg_rdata <= cfg;
        `ADM_ADDR_CONTROL:    reg_rdata <= ctl;
        `ADM_ADDR_RESULT_HI:  reg_rdata <= readback[23:16];
        `ADM_ADDR_RESULT_MID: reg_rdata <= readback[15:8];
        `ADM_ADDR_RESULT_LO:  reg_rdata <= readback[7:0];
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // adm_top

// ==== testbench/adm_mic_model.sv ====
// Digital microphone model driving the single-bit stream
`timescale 1ns/1ps
module adm_mic_model (
  input  wire  mic_clk,
  input  wire  mic_en,
  output logic data_out
);
  logic [2:0] pat = 3'b011;
  // New bit launched on the falling edge, steady at the rising edge
  always @(negedge mic_clk) begin
    pat <= {pat[1:0], pat[2]};
  end
  // Without a clock on the pin the line shows the inverse of the held bit
  assign data_out = mic_en ? pat[0] : ~pat[0];
endmodule // adm_mic_model

// ==== testbench/adm_top_asserts.sv ====
// Port assertions for the decimation back end
`timescale 1ns/1ps
module adm_top_asserts #(
  parameter MOD_DIV = 8
) (
  input wire        clk,
  input wire        rst,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [7:0]  reg_rdata,
  input wire [3:0]  pin_function,
  input wire [4:0]  word_length,
  input wire        general_pin_one,
  input wire        general_pin_one_oe,
  input wire [31:0] left_word,
  input wire [31:0] right_word,
  input wire        word_valid
);
  reg dc_on;
  always @(posedge clk or posedge rst) begin
    if (rst) dc_on <= 1'b0;
    else if (reg_write && reg_addr == 8'h66) dc_on <= reg_wdata[7];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_func_on;
    (pin_function == 4'hA) [*2];
  endsequence
  sequence s_func_off;
    (pin_function != 4'hA) [*2];
  endsequence
  a_pin_drive_on: assert property (s_func_on |-> general_pin_one_oe)
    else $error("pin not driven");
  a_pin_drive_off: assert property (s_func_off |-> !general_pin_one_oe && !general_pin_one)
    else $error("pin driven");
  a_slots_equal: assert property (word_valid |-> left_word == right_word)
    else $error("slots differ");
  a_sample_spacing: assert property (word_valid |=> !word_valid [*8])
    else $error("samples too close");
  a_word_hold: assert property ($changed(left_word) |-> word_valid)
    else $error("word changed between samples");
  a_word_round: assert property (word_valid && $past(word_length) != 5'h00 |->
    (left_word & (32'hFFFFFFFF >> $past(word_length))) == 32'h00000000)
    else $error("word not rounded");
  a_dc_quiet: assert property (dc_on && $past(dc_on) |-> !word_valid)
    else $error("samples in dc mode");
  a_unmapped_zero: assert property (reg_read && reg_addr < 8'h66 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule // adm_top_asserts
bind adm_top adm_top_asserts #(.MOD_DIV(MOD_DIV)) i_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .pin_function(pin_function), .word_length(word_length),
  .general_pin_one(general_pin_one), .general_pin_one_oe(general_pin_one_oe),
  .left_word(left_word), .right_word(right_word), .word_valid(word_valid));

// ==== testbench/testbench.sv ====
// Self-checking bench for the decimation back end
`timescale 1ns/1ps
`include "adm_defines.vh"
module testbench;
  logic        clk, rst, reg_write, reg_read, dig_mic_enable, mod_bit, prev;
  logic [7:0]  reg_addr, reg_wdata, adc_oversampling_ratio, reg_rdata, rd_q;
  logic [3:0]  pin_function;
  logic [1:0]  filter_select;
  logic [4:0]  word_length;
  logic [31:0] left_word, right_word;
  logic        general_pin_one, general_pin_one_oe, word_valid, serial_data_in;
  logic [23:0] res_a, res_b;
  int          err_total = 0, n_checks = 0, cyc = 0, gap, k, j;
  int          t_gap [5] = '{512, 256, 256, 128, 256};
  logic [1:0]  t_sel [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  logic [7:0]  t_osr [5] = '{8'h80, 8'h40, 8'h80, 8'h80, 8'h40};
  adm_top #(.MOD_DIV(2)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_function(pin_function), .filter_select(filter_select),
    .adc_oversampling_ratio(adc_oversampling_ratio), .dig_mic_enable(dig_mic_enable),
    .mod_bit(mod_bit), .serial_data_in(serial_data_in), .word_length(word_length),
    .general_pin_one(general_pin_one), .general_pin_one_oe(general_pin_one_oe),
    .left_word(left_word), .right_word(right_word), .word_valid(word_valid));
  adm_mic_model i_mic (.mic_clk(general_pin_one), .mic_en(general_pin_one_oe),
    .data_out(serial_data_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk) #1 reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk) #1 reg_read = 1'b0;
    d = reg_rdata;
  endtask
  task automatic rd_result(output logic [23:0] r);
    rd(`ADM_ADDR_RESULT_HI, r[23:16]);
    rd(`ADM_ADDR_RESULT_MID, r[15:8]);
    rd(`ADM_ADDR_RESULT_LO, r[7:0]);
  endtask
  task automatic next_valid(output int n);
    n = 0;
    do @(posedge clk) #1 n++; while (word_valid !== 1'b1 && n < 3000);
  endtask
  initial begin
    {rst, reg_write, reg_read, dig_mic_enable, mod_bit, reg_addr, reg_wdata} = '0;
    {pin_function, filter_select, word_length} = '0;
    adc_oversampling_ratio = `ADM_OSR_128;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    wr(`ADM_ADDR_CONFIG, 8'h05);
    rd(`ADM_ADDR_CONFIG, rd_q);
    check(rd_q, 8'h05);
    wr(`ADM_ADDR_CONTROL, 8'h25);
    rd(`ADM_ADDR_CONTROL, rd_q);
    check(rd_q, 8'h25);
    rd(8'h10, rd_q);
    check(rd_q, 8'h00);
    wr(`ADM_ADDR_CONTROL, 8'h00);
    $display("registers test done");
    pin_function = `ADM_PIN_FUNC_MODCLK;
    repeat (4) @(posedge clk) #1 k = 0;
    prev = general_pin_one;
    repeat (40) @(posedge clk) #1 begin
      k += (general_pin_one !== prev);
      prev = general_pin_one;
    end
    check(general_pin_one_oe, 1'b1);
    check(k, 20);
    $display("clock pin test done");
    for (j = 0; j < 5; j++) begin
      filter_select = t_sel[j];
      adc_oversampling_ratio = t_osr[j];
      dig_mic_enable = (j == 4);
      word_length = (j == 4) ? 5'h10 : 5'h00;
      mod_bit = j[0];
      next_valid(gap);
      next_valid(gap);
      check(gap, t_gap[j]);
      check(left_word, right_word);
    end
    check(left_word[15:0], 16'h0000);
    $display("decimation test done");
    for (j = 0; j < 2; j++) begin
      wr(`ADM_ADDR_CONFIG, j ? 8'hA3 : 8'h82);
      wr(`ADM_ADDR_CONTROL, j ? 8'h25 : 8'h29);
      k = 0;
      repeat (3000) @(posedge clk) #1 k += word_valid;
      check(k, 0);
      wr(`ADM_ADDR_CONTROL, j ? 8'h65 : 8'h69);
      rd_result(res_a);
      check({res_a[23], |res_a}, 2'b01);
      repeat (1100) @(posedge clk);
      rd_result(res_b);
      check(res_b, res_a);
      wr(`ADM_ADDR_CONTROL, 8'h00);
    end
    $display("dc measurement test done");
    give_verdict();
  end
endmodule // testbench
